// [logic/pmt_terminal_logic.sv]
// terminal function logic for pulse-train position control
//
// What this block does
// - mode 4 makes fwd/rev limits and servo enable; mode 0 run commands
// - position mode: speed-reached output serves as positioning complete
// - deviation counter clears on falling edge of clear input
// - ready only while servo enabled and operation can start
// - one zero-phase output pulse per motor revolution
// - forward limit open: stop, servo lock, reverse still allowed
// - reverse limit open: stop, servo lock, forward still allowed
// - ready asserted 0.1 s after servo enable releases output stage
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module pmt_terminal_logic
  import pmt_pkg::*;
#(
  parameter int READY_DELAY = READY_CYCLES,
  parameter int PULSES_PER_REV = 1024,
  parameter int COUNT_W = 16,
  parameter int IN_POS_WIDTH = 100
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // contact inputs, high means shorted to common
  input wire logic fwdLimitOrRunIn,
  input wire logic revLimitOrRunIn,
  input wire logic servoEnableIn,
  input wire logic deviationClearIn,
  input wire logic resetIn,
  // command and feedback pulses, one-cycle signed steps
  input wire logic fwdPulseIn,
  input wire logic revPulseIn,
  input wire logic fbFwdStep,
  input wire logic fbRevStep,
  // motion control and terminal outputs
  output logic baseReleased,
  output logic servoLock,
  output logic fwdAllowed,
  output logic revAllowed,
  output logic fwdRunCmd,
  output logic revRunCmd,
  output logic multiIn1,
  output logic faultReset,
  output logic readyOut,
  output logic zeroPhasePulseOut,
  output logic speedReachedOut,
  output logic irq
);

  // refused at elaboration: counters and the in-position compare cannot serve these
  if (READY_DELAY < 1 || PULSES_PER_REV < 2 || COUNT_W < 4 || COUNT_W > 31
      || IN_POS_WIDTH < 0 || IN_POS_WIDTH >= 2 ** (COUNT_W - 1))
    $error("pmt_terminal_logic: unsupported parameter values");

  localparam int RCW = $clog2(READY_DELAY + 1);
  localparam int PCW = $clog2(PULSES_PER_REV);

  logic [31:0] ctrl_r;
  logic [EV_W-1:0] irqStat_r;
  logic [EV_W-1:0] irqMask_r;
  logic [RCW-1:0] readyCnt_r;
  logic ready_r;
  logic readyEn;
  logic clearPrev_r;
  logic signed [COUNT_W-1:0] devCnt_r;
  logic [PCW-1:0] revCnt_r;
  logic zp_r;
  logic fwdStop_r;
  logic revStop_r;
  logic [3:0] mode;
  logic posActive;
  logic wrEn;
  logic rdEn;
  logic clearFall;
  logic fwdLimEv;
  logic revLimEv;
  logic readyEv;
  logic revEv;
  logic [EV_W-1:0] events;
  logic inPos;

  function automatic logic [COUNT_W-1:0] absVal(input logic signed [COUNT_W-1:0] v);
    absVal = v[COUNT_W-1] ? COUNT_W'(-v) : COUNT_W'(v);
  endfunction

  assign mode = ctrl_r[CTRL_MODE_LSB +: 4];

  // changeover modes take the terminal meaning of the running sub-mode
  always_comb
  begin
    case (mode)
      MODE_POSITION: posActive = 1'b1;
      MODE_SPD_POS: posActive = ctrl_r[CTRL_SUBPOS_BIT];
      MODE_POS_TRQ: posActive = ctrl_r[CTRL_SUBPOS_BIT];
      default: posActive = 1'b0;
    endcase
  end

  // apb: zero wait, answer in the access cycle
  assign pready = 1'b1;
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;
  always_comb
  begin
    pslverr = 1'b0;
    if (psel && penable)
    begin
      case (paddr)
        OFS_CTRL, OFS_STATUS, OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_DEVCNT: pslverr = 1'b0;
        default: pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      prdata <= 32'h0000_0000;
    else if (psel && !penable)
    begin
      case (paddr)
        OFS_CTRL: prdata <= ctrl_r;
        OFS_STATUS: prdata <= {26'h0, posActive, inPos, revStop_r, fwdStop_r, baseReleased, ready_r};
        OFS_IRQ_STAT: prdata <= {27'h0, irqStat_r};
        OFS_IRQ_MASK: prdata <= {27'h0, irqMask_r};
        OFS_DEVCNT: prdata <= 32'(devCnt_r);
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      ctrl_r <= CTRL_RESET;
    else if (wrEn && paddr == OFS_CTRL && pwdata[3:0] <= MODE_MAX)
      ctrl_r <= {26'h0, pwdata[5:0]}; // codes above 6 ignored
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      irqMask_r <= '0;
    else if (wrEn && paddr == OFS_IRQ_MASK)
      irqMask_r <= pwdata[EV_W-1:0];
  end

  // read clears, a same-cycle event survives
  always_ff @(posedge clk)
  begin
    if (reset)
      irqStat_r <= '0;
    // clear only what the read returned; an event at the setup edge is kept
    else if (rdEn && paddr == OFS_IRQ_STAT)
      irqStat_r <= (irqStat_r & ~prdata[EV_W-1:0]) | events;
    else
      irqStat_r <= irqStat_r | events;
  end
  assign irq = |(irqStat_r & irqMask_r);

  // terminal mapping
  assign baseReleased = posActive ? servoEnableIn : 1'b1;
  assign fwdRunCmd = !posActive && fwdLimitOrRunIn;
  assign revRunCmd = !posActive && revLimitOrRunIn;
  assign multiIn1 = !posActive && servoEnableIn;
  assign faultReset = resetIn;

  // limit stops: an open limit blocks only its own direction
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      fwdStop_r <= 1'b0;
      revStop_r <= 1'b0;
    end
    else
    begin
      fwdStop_r <= posActive && !fwdLimitOrRunIn;
      revStop_r <= posActive && !revLimitOrRunIn;
    end
  end
  assign fwdAllowed = baseReleased && !fwdStop_r;
  assign revAllowed = baseReleased && !revStop_r;
  assign servoLock = posActive && servoEnableIn && (fwdStop_r || revStop_r || !ready_r);
  assign fwdLimEv = posActive && !fwdLimitOrRunIn && !fwdStop_r;
  assign revLimEv = posActive && !revLimitOrRunIn && !revStop_r;

  // ready delay counter restarts whenever enable drops
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      readyCnt_r <= '0;
      ready_r <= 1'b0;
    end
    else if (!readyEn)
    begin
      readyCnt_r <= '0;
      ready_r <= 1'b0;
    end
    else if (readyCnt_r == RCW'(READY_DELAY - 1))
      ready_r <= 1'b1;
    else
      readyCnt_r <= readyCnt_r + 1'b1;
  end
  assign readyEn = posActive && servoEnableIn && ctrl_r[CTRL_CANRUN_BIT];
  // gated so ready falls with enable instead of one cycle late
  assign readyOut = ready_r && readyEn;
  assign readyEv = readyEn && !ready_r
                   && readyCnt_r == RCW'(READY_DELAY - 1);

  // deviation counter; commands count only while positioning runs
  always_ff @(posedge clk)
  begin
    if (reset)
      clearPrev_r <= 1'b0;
    else
      clearPrev_r <= deviationClearIn;
  end
  // contact shorted reads high, so the electrical falling edge is our rise
  assign clearFall = deviationClearIn && !clearPrev_r;

  always_ff @(posedge clk)
  begin
    if (reset)
      devCnt_r <= '0;
    else if (clearFall)
      devCnt_r <= '0;
    else if (ready_r)
      devCnt_r <= devCnt_r
                  + COUNT_W'(fwdPulseIn && fwdAllowed)
                  - COUNT_W'(revPulseIn && revAllowed)
                  - COUNT_W'(fbFwdStep)
                  + COUNT_W'(fbRevStep);
  end
  assign inPos = posActive && absVal(devCnt_r) <= COUNT_W'(IN_POS_WIDTH);

  // speed-reached doubles as positioning complete in position mode
  always_ff @(posedge clk)
  begin
    if (reset)
      speedReachedOut <= 1'b0;
    else
      speedReachedOut <= posActive ? inPos : (fwdRunCmd ^ revRunCmd);
  end

  // revolution counter; pulses once per turn in either direction
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      revCnt_r <= '0;
      zp_r <= 1'b0;
    end
    else
    begin
      zp_r <= 1'b0;
      if (fbFwdStep && !fbRevStep)
      begin
        if (revCnt_r == PCW'(PULSES_PER_REV - 1))
        begin
          revCnt_r <= '0;
          zp_r <= 1'b1;
        end
        else
          revCnt_r <= revCnt_r + 1'b1;
      end
      else if (fbRevStep && !fbFwdStep)
      begin
        if (revCnt_r == '0)
        begin
          revCnt_r <= PCW'(PULSES_PER_REV - 1);
          zp_r <= 1'b1;
        end
        else
          revCnt_r <= revCnt_r - 1'b1;
      end
    end
  end
  assign zeroPhasePulseOut = zp_r;
  assign revEv = zp_r;

  assign events = {revEv, readyEv, revLimEv, fwdLimEv, clearFall};

  // checks
  clear_zeroes_a: assert property (@(posedge clk) disable iff (reset)
    clearFall |=> devCnt_r == '0) else $error("clear did not zero counter");
  ready_needs_en_a: assert property (@(posedge clk) disable iff (reset)
    readyOut |-> servoEnableIn && posActive) else $error("ready without enable");
  ready_delay_a: assert property (@(posedge clk) disable iff (reset)
    $rose(readyOut) |-> $past(readyCnt_r) == RCW'(READY_DELAY - 1)) else $error("ready delay wrong");
  fwd_limit_a: assert property (@(posedge clk) disable iff (reset)
    (posActive && !fwdLimitOrRunIn) ##1 (posActive && !fwdLimitOrRunIn) |-> !fwdAllowed)
    else $error("forward not blocked");
  rev_limit_a: assert property (@(posedge clk) disable iff (reset)
    (posActive && !revLimitOrRunIn) ##1 (posActive && !revLimitOrRunIn) |-> !revAllowed)
    else $error("reverse not blocked");
  rev_other_a: assert property (@(posedge clk) disable iff (reset)
    fwdStop_r && !revStop_r && baseReleased |-> revAllowed) else $error("reverse blocked by fwd limit");
  zp_single_a: assert property (@(posedge clk) disable iff (reset)
    zeroPhasePulseOut |=> !zeroPhasePulseOut) else $error("zero pulse too long");
  mode_map_a: assert property (@(posedge clk) disable iff (reset)
    mode == MODE_POSITION |-> !fwdRunCmd && !revRunCmd && !multiIn1) else $error("position map wrong");
  speed_map_a: assert property (@(posedge clk) disable iff (reset)
    mode == MODE_SPEED |-> fwdRunCmd == fwdLimitOrRunIn && multiIn1 == servoEnableIn)
    else $error("speed map wrong");
  no_pos_open_a: assert property (@(posedge clk) disable iff (reset)
    posActive && !servoEnableIn |-> !baseReleased && !readyOut) else $error("positioning while open");
  inpos_out_a: assert property (@(posedge clk) disable iff (reset)
    posActive && $past(posActive) |-> speedReachedOut == $past(inPos)) else $error("complete flag wrong");
  changeover_a: assert property (@(posedge clk) disable iff (reset)
    mode == MODE_SPD_POS |-> posActive == ctrl_r[CTRL_SUBPOS_BIT]) else $error("changeover map wrong");
  pos_trq_map_a: assert property (@(posedge clk) disable iff (reset)
    mode == MODE_POS_TRQ |-> posActive == ctrl_r[CTRL_SUBPOS_BIT]) else $error("pos/torque map wrong");
  ready_early_a: assert property (@(posedge clk) disable iff (reset)
    readyOut |-> readyCnt_r == RCW'(READY_DELAY - 1)) else $error("ready before delay");
  open_no_cmd_a: assert property (@(posedge clk) disable iff (reset)
    posActive && !servoEnableIn |-> !fwdAllowed && !revAllowed) else $error("motion while open");
  stat_keep_a: assert property (@(posedge clk) disable iff (reset)
    |events |=> (irqStat_r & $past(events)) == $past(events)) else $error("event lost");

  ready_seen_c: cover property (@(posedge clk) disable iff (reset) $rose(readyOut));
  clear_seen_c: cover property (@(posedge clk) disable iff (reset) clearFall && devCnt_r != '0);
  limit_seen_c: cover property (@(posedge clk) disable iff (reset) fwdStop_r && revAllowed);
  turn_seen_c: cover property (@(posedge clk) disable iff (reset) zeroPhasePulseOut);
  subpos_seen_c: cover property (@(posedge clk) disable iff (reset) mode == MODE_POS_TRQ && posActive);

endmodule
`default_nettype wire

// [logic/pmt_pkg.sv]
// constants for the position-mode terminal logic
package pmt_pkg;
  // control mode codes
  localparam logic [3:0] MODE_SPEED = 4'h0;
  localparam logic [3:0] MODE_TORQUE = 4'h1;
  localparam logic [3:0] MODE_SPD_TRQ = 4'h2;
  localparam logic [3:0] MODE_SPD_VI = 4'h3;
  localparam logic [3:0] MODE_POSITION = 4'h4;
  localparam logic [3:0] MODE_SPD_POS = 4'h5;
  localparam logic [3:0] MODE_POS_TRQ = 4'h6;
  localparam logic [3:0] MODE_MAX = 4'h6;
  // register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h008;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h00C;
  localparam logic [11:0] OFS_DEVCNT = 12'h010;
  // control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SUBPOS_BIT = 4;
  localparam int CTRL_CANRUN_BIT = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // status fields
  localparam int ST_READY = 0;
  localparam int ST_BASE = 1;
  localparam int ST_FWDLIM = 2;
  localparam int ST_REVLIM = 3;
  localparam int ST_INPOS = 4;
  localparam int ST_POSACT = 5;
  // interrupt event bits
  localparam int EV_CLEAR = 0;
  localparam int EV_FWDLIM = 1;
  localparam int EV_REVLIM = 2;
  localparam int EV_READY = 3;
  localparam int EV_REV = 4;
  localparam int EV_W = 5;
  // ready delay after servo enable
  localparam real READY_DELAY_S = 0.1;
  localparam real CLK_HZ = 100.0e6;
  localparam int READY_CYCLES = int'(READY_DELAY_S * CLK_HZ);
endpackage

// [testbench/pmt_ctl_model.sv]
// external positioning controller model
`timescale 1ns/1ns
`default_nettype none
module pmt_ctl_model #(
  parameter int PULSE_GAP = 500
)
(
  // clock
  input wire logic clk,
  // contacts and command pulses
  output logic servoOn,
  output logic fwdPulse,
  output logic revPulse
);
  initial
  begin
    servoOn = 1'b0;
    fwdPulse = 1'b0;
    revPulse = 1'b0;
  end
  // gap keeps step rate at the input limit or below
  task automatic send(input int n, input logic dir);
    repeat (n)
    begin
      @(posedge clk);
      fwdPulse <= !dir;
      revPulse <= dir;
      @(posedge clk);
      fwdPulse <= 1'b0;
      revPulse <= 1'b0;
      repeat (PULSE_GAP) @(posedge clk);
    end
  endtask
  // servo enable held shorted while positioning
  task automatic servo(input logic on);
    @(posedge clk);
    servoOn <= on;
  endtask
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the terminal logic
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module testbench
  import pmt_pkg::*;
;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, rse;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic fwdLim, revLim, servoOn, clr, resIn, fwdP, revP, fbF, fbR;
  logic bRel, sLock, fwdOk, revOk, fwdRun, revRun, mIn1, fRes, rdy, zp, spd, irq;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int zc = 0;
  int n;
  pmt_terminal_logic #(.READY_DELAY(20), .PULSES_PER_REV(8)) i_dut (.clk(clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fwdLimitOrRunIn(fwdLim),
    .revLimitOrRunIn(revLim), .servoEnableIn(servoOn), .deviationClearIn(clr), .resetIn(resIn),
    .fwdPulseIn(fwdP), .revPulseIn(revP), .fbFwdStep(fbF), .fbRevStep(fbR),
    .baseReleased(bRel), .servoLock(sLock), .fwdAllowed(fwdOk), .revAllowed(revOk),
    .fwdRunCmd(fwdRun), .revRunCmd(revRun), .multiIn1(mIn1), .faultReset(fRes),
    .readyOut(rdy), .zeroPhasePulseOut(zp), .speedReachedOut(spd), .irq(irq));
  pmt_ctl_model i_ctl (.clk(clk), .servoOn(servoOn), .fwdPulse(fwdP), .revPulse(revP));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic conclude;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // a hang counts as a failure
  always @(posedge clk)
  begin
    cyc++;
    zc += int'(zp);
    if (cyc == 10000)
    begin
      n_errors++;
      conclude();
    end
  end
  task automatic wt(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    rse = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic step(input bit rev);
    @(posedge clk);
    fbF <= !rev;
    fbR <= rev;
    @(posedge clk);
    fbF <= 1'b0;
    fbR <= 1'b0;
  endtask
  initial
  begin
    {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    {fwdLim, revLim, clr, resIn, fbF, fbR} = 6'b110000;
    wt(4);
    reset <= 1'b0;
    apb(0, OFS_CTRL, 0);
    `CHK("ctrl", CTRL_RESET, q)
    apb(0, 12'h020, 0);
    `CHK("slverr", 1'b1, rse)
    resIn <= 1'b1;
    apb(1, OFS_CTRL, 32'h7);
    apb(0, OFS_CTRL, 0);
    `CHK("badMode", CTRL_RESET, q)
    `CHK("fwdRun", 1'b1, fwdRun)
    `CHK("multiIn", 1'b0, mIn1)
    `CHK("fltRes", 1'b1, fRes)
    apb(1, OFS_IRQ_MASK, 32'h1F);
    apb(1, OFS_CTRL, 32'h24);
    wt(1);
    `CHK("posRun", 1'b0, fwdRun)
    i_ctl.servo(1'b1);
    n = 0;
    while (rdy !== 1'b1 && n < 100)
    begin
      wt(1);
      n++;
    end
    `CHK("rdyDelay", 1'b1, n >= 19 && n <= 24)
    `CHK("irqOn", 1'b1, irq)
    apb(0, OFS_IRQ_STAT, 0);
    `CHK("evReady", 1'b1, q[EV_READY])
    wt(1);
    `CHK("irqClr", 1'b0, irq)
    i_ctl.send(3, 1'b0);
    apb(0, OFS_DEVCNT, 0);
    `CHK("dev3", 32'h3, q)
    step(0);
    apb(0, OFS_DEVCNT, 0);
    `CHK("dev2", 32'h2, q)
    `CHK("inPos", 1'b1, spd)
    clr <= 1'b1;
    apb(0, OFS_DEVCNT, 0);
    `CHK("devClr", 32'h0, q)
    clr <= 1'b0;
    fwdLim <= 1'b0;
    wt(3);
    `CHK("fwdStop", 3'b011, {fwdOk, revOk, sLock})
    fwdLim <= 1'b1;
    revLim <= 1'b0;
    wt(3);
    `CHK("revStop", 3'b011, {revOk, fwdOk, sLock})
    revLim <= 1'b1;
    apb(0, OFS_IRQ_STAT, 0);
    `CHK("evLim", 3'b111, {q[EV_CLEAR], q[EV_FWDLIM], q[EV_REVLIM]})
    apb(1, OFS_IRQ_MASK, 0);
    fwdLim <= 1'b0;
    wt(3);
    `CHK("irqMask", 1'b0, irq)
    fwdLim <= 1'b1;
    apb(0, OFS_IRQ_STAT, 0);
    `CHK("evMasked", 1'b1, q[EV_FWDLIM])
    zc = 0;
    repeat (16) step(0);
    wt(3);
    `CHK("zeroPh", 2, zc)
    i_ctl.servo(1'b0);
    wt(3);
    `CHK("rdyDrop", 1'b0, rdy)
    `CHK("baseOpen", 1'b0, bRel)
    i_ctl.send(1, 1'b0);
    apb(0, OFS_DEVCNT, 0);
    `CHK("devHold", 32'hFFFF_FFF0, q)
    for (int m = 5; m <= 6; m++)
    begin
      apb(1, OFS_CTRL, 32'(m));
      wt(1);
      `CHK("subSpd", 2'b11, {fwdRun, revRun})
      apb(1, OFS_CTRL, 32'(m) | 32'h10);
      wt(1);
      `CHK("subPos", 3'b001, {fwdRun, revRun, fRes})
    end
    conclude();
  end
endmodule
`default_nettype wire
